// [rtl/mbfd_pkg.sv]
// constants for the macroblock field-select decoder
// assumes the record words arrive already fetched from memory, on core_clk
package mbfd_pkg;

  // ==========================================================================
  // pattern dword fields
  localparam int unsigned CBP_MSB        = 11;  // coded-block-pattern mask top bit
  localparam int unsigned CBP_LSB        = 6;   // coded-block-pattern mask low bit
  localparam int unsigned CBP_WIDTH      = CBP_MSB - CBP_LSB + 1;
  localparam int unsigned BLUE_CHROMA_BIT = 7;  // blue-difference chroma block
  localparam int unsigned RED_CHROMA_BIT  = 6;  // red-difference chroma block

  // ==========================================================================
  // record word one, low half
  localparam int unsigned VFS_LSB        = 28;  // vertical field select, index 0,0
  localparam int unsigned VFS_MSB        = 31;  // vertical field select, index 1,1
  localparam int unsigned VFS_COUNT      = VFS_MSB - VFS_LSB + 1;
  localparam int unsigned SECOND_FIELD_BIT = 27;

  // ==========================================================================
  // field-select encoding
  localparam logic FIELD_TOP    = 1'b0;
  localparam logic FIELD_BOTTOM = 1'b1;

  // ==========================================================================
  // reset values
  localparam logic [CBP_WIDTH-1:0] CBP_RESET = 6'h00;
  localparam logic [VFS_COUNT-1:0] VFS_RESET = 4'h0;

endpackage : mbfd_pkg

// [rtl/mbfd_field_ref.sv]
// reference picking for one field-select flag
// assumes pure combinational use; the caller registers the results
module mbfd_field_ref
  import mbfd_pkg::*;
(
  input  wire logic selectBit,
  input  wire logic secondField,
  input  wire logic fieldPPicture,
  input  wire logic currentIsBottom,
  output logic      fromBottomField,
  output logic      fromCurrentFrame
);

  // ==========================================================================
  // field parity and frame choice
  // a flag of 0 means the top field, 1 the bottom field
  assign fromBottomField  = (selectBit == FIELD_BOTTOM);
  // second field of a field P-picture: the opposite-parity field is the
  // first field of this same frame; everything else comes from the prior frame
  assign fromCurrentFrame = fieldPPicture & secondField & (selectBit != currentIsBottom);

endmodule : mbfd_field_ref

// [rtl/mbfd_decode.sv]
// macroblock record decoder: block-present flags, field selects, second field
// assumes record words and picture context come from logic on core_clk
// Operation
// - six pattern bits become block-present flags; bit 7 blue, bit 6 red chroma
// - reserved pattern bits 5:0 and all of word one high are ignored
// - bits 31:28 form a 2x2 select array by vector number and direction
// - select flag 0 fetches from top field, 1 from bottom field
// - bit 27 set marks the macroblock as in the second field
// - in field P-pictures the second-field flag picks the reference frame
module mbfd_decode
  import mbfd_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 recordValid,
  input  wire logic [31:0]          patternWord,
  input  wire logic [31:0]          recordWordOneHigh,
  input  wire logic [31:0]          recordWordOneLow,
  input  wire logic                 pPicture,
  input  wire logic                 fieldPrediction,
  input  wire logic                 currentIsBottom,
  output logic                      decodeValid_ff,
  output logic [CBP_WIDTH-1:0]      blockPresent_ff,
  output logic                      blueChromaBlockPresent_ff,
  output logic                      redChromaBlockPresent_ff,
  output logic [VFS_COUNT-1:0]      verticalFieldSelectIndex_ff,
  output logic [VFS_COUNT-1:0]      refFromBottom_ff,
  output logic [VFS_COUNT-1:0]      refFromCurrentFrame_ff,
  output logic                      secondField_ff,
  output logic                      secondFieldMisuse_ff
);

  // ==========================================================================
  // field extraction
  logic [CBP_WIDTH-1:0] nxt_blockPresent;
  logic [VFS_COUNT-1:0] selBits;
  logic                 secondFieldBit;
  logic                 fieldPPicture;
  logic [VFS_COUNT-1:0] nxt_fromBottom;
  logic [VFS_COUNT-1:0] nxt_fromCurrent;

  // only the named bit ranges are tapped; the reserved ranges and word one
  // high are never read, so their contents cannot reach any flop
  assign nxt_blockPresent = patternWord[CBP_MSB:CBP_LSB];
  assign selBits          = recordWordOneLow[VFS_MSB:VFS_LSB];
  assign secondFieldBit   = recordWordOneLow[SECOND_FIELD_BIT];
  assign fieldPPicture    = pPicture & fieldPrediction;

  // ==========================================================================
  // one reference picker per select flag, index = vector*2 + direction
  genvar gi;
  generate
    for (gi = 0; gi < VFS_COUNT; gi++) begin : g_sel
      mbfd_field_ref u_ref (
        .selectBit        (selBits[gi]),
        .secondField      (secondFieldBit),
        .fieldPPicture    (fieldPPicture),
        .currentIsBottom  (currentIsBottom),
        .fromBottomField  (nxt_fromBottom[gi]),
        .fromCurrentFrame (nxt_fromCurrent[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // valid strobe, one cycle after each taken record
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      decodeValid_ff <= 1'b0;
    end else begin
      decodeValid_ff <= recordValid;
    end
  end

  // block-present flags, held until the next record
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blockPresent_ff           <= CBP_RESET;
      blueChromaBlockPresent_ff <= 1'b0;
      redChromaBlockPresent_ff  <= 1'b0;
    end else if (recordValid) begin
      blockPresent_ff           <= nxt_blockPresent;
      blueChromaBlockPresent_ff <= patternWord[BLUE_CHROMA_BIT];
      redChromaBlockPresent_ff  <= patternWord[RED_CHROMA_BIT];
    end
  end

  // field selects and reference choice
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      verticalFieldSelectIndex_ff <= VFS_RESET;
      refFromBottom_ff            <= VFS_RESET;
      refFromCurrentFrame_ff      <= VFS_RESET;
    end else if (recordValid) begin
      verticalFieldSelectIndex_ff <= selBits;
      refFromBottom_ff            <= nxt_fromBottom;
      refFromCurrentFrame_ff      <= nxt_fromCurrent;
    end
  end

  // second field flag; misuse is reported, not corrected, since the
  // producer owns the encoding and the frame choice already ignores it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      secondField_ff       <= 1'b0;
      secondFieldMisuse_ff <= 1'b0;
    end else if (recordValid) begin
      secondField_ff       <= secondFieldBit;
      secondFieldMisuse_ff <= secondFieldBit & ~fieldPPicture;
    end
  end

  // ==========================================================================
  // checks
  // all checks sample on core_clk and sleep while reset is low
  // one taken record and its strobe
  sequence s_take;
    recordValid ##1 decodeValid_ff;
  endsequence

  // a gap of two idle cycles, used by the hold checks
  sequence s_idle2;
    !recordValid [*2];
  endsequence

  // record taken in a field P-picture, second field
  sequence s_second_p;
    recordValid && pPicture && fieldPrediction && recordWordOneLow[SECOND_FIELD_BIT];
  endsequence

  // chroma flags follow pattern bits 7 and 6
  property p_blue;
    @(posedge core_clk) disable iff (!rst_n)
      recordValid |=> blueChromaBlockPresent_ff == $past(patternWord[BLUE_CHROMA_BIT]);
  endproperty

  blue_chroma_a: assert property (p_blue) else $error("blue chroma flag wrong");

  red_chroma_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid |=> redChromaBlockPresent_ff == $past(patternWord[RED_CHROMA_BIT]))
    else $error("red chroma flag wrong");

  mask_ties_chroma_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    decodeValid_ff |-> blockPresent_ff[BLUE_CHROMA_BIT-CBP_LSB] == blueChromaBlockPresent_ff
      && blockPresent_ff[RED_CHROMA_BIT-CBP_LSB] == redChromaBlockPresent_ff)
    else $error("mask and chroma flags disagree");

  reserved_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_take |-> blockPresent_ff == $past(patternWord[CBP_MSB:CBP_LSB])
      && secondField_ff == $past(recordWordOneLow[SECOND_FIELD_BIT]))
    else $error("output not a function of named bits");

  // outer select bits, index 0,0 and 1,1
  select_array_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid |=> verticalFieldSelectIndex_ff[0] == $past(recordWordOneLow[VFS_LSB])
      && verticalFieldSelectIndex_ff[VFS_COUNT-1] == $past(recordWordOneLow[VFS_MSB]))
    else $error("select array bit order wrong");

  // middle select bits, index 0,1 and 1,0
  select_middle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid |=> verticalFieldSelectIndex_ff[1] == $past(recordWordOneLow[VFS_LSB+1])
      && verticalFieldSelectIndex_ff[2] == $past(recordWordOneLow[VFS_LSB+2]))
    else $error("middle select bits wrong");

  parity_pick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    decodeValid_ff |-> refFromBottom_ff == verticalFieldSelectIndex_ff)
    else $error("field parity pick wrong");

  // parity taken straight from the record word, not from another output
  bottom_from_word_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid |=> refFromBottom_ff == $past(recordWordOneLow[VFS_MSB:VFS_LSB]))
    else $error("bottom field pick not from select bits");

  // second field and frame choice
  second_field_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid |=> secondField_ff == $past(recordWordOneLow[SECOND_FIELD_BIT]))
    else $error("second field flag wrong");

  frame_pick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid && !(pPicture && fieldPrediction) |=> refFromCurrentFrame_ff == VFS_RESET)
    else $error("current frame chosen outside field P");

  first_field_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid && !recordWordOneLow[SECOND_FIELD_BIT] |=> refFromCurrentFrame_ff == VFS_RESET)
    else $error("current frame chosen in first field");

  // second field of a field P-picture: opposite parity comes from this frame
  current_pick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_second_p |=> refFromCurrentFrame_ff
      == ($past(recordWordOneLow[VFS_MSB:VFS_LSB]) ^ {VFS_COUNT{$past(currentIsBottom)}}))
    else $error("current frame pick wrong in second field");

  // misuse report and idle hold
  misuse_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid |=> secondFieldMisuse_ff == ($past(recordWordOneLow[SECOND_FIELD_BIT])
      && !($past(pPicture) && $past(fieldPrediction))))
    else $error("misuse flag wrong");

  // a record inside field P is never reported as misuse
  misuse_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid && pPicture && fieldPrediction |=> !secondFieldMisuse_ff)
    else $error("misuse reported inside field P");

  hold_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_idle2 |-> $stable(blockPresent_ff) && $stable(refFromCurrentFrame_ff) && !decodeValid_ff)
    else $error("outputs moved without a record");

  // remaining outputs also hold through gaps
  hold_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_idle2 |-> $stable(verticalFieldSelectIndex_ff) && $stable(refFromBottom_ff)
      && $stable(secondField_ff) && $stable(secondFieldMisuse_ff)
      && $stable(blueChromaBlockPresent_ff) && $stable(redChromaBlockPresent_ff))
    else $error("held outputs moved without a record");

  // answer timing: exactly one strobe per taken record
  valid_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    recordValid |=> decodeValid_ff)
    else $error("record taken without a strobe");

  valid_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !recordValid |=> !decodeValid_ff)
    else $error("strobe without a record");

endmodule : mbfd_decode

// [testbench/tb_top.sv]
// self-checking bench for the macroblock field-select decoder
// assumes the decoder answers one cycle after each taken record
module tb_top
  import mbfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // stimulus and result signals
  logic                 core_clk, rst_n, recordValid, pPicture, fieldPrediction, currentIsBottom;
  logic [31:0]          patternWord, recordWordOneHigh, recordWordOneLow, seed;
  logic                 decodeValid_ff, blueChromaBlockPresent_ff, redChromaBlockPresent_ff;
  logic                 secondField_ff, secondFieldMisuse_ff;
  logic [CBP_WIDTH-1:0] blockPresent_ff;
  logic [VFS_COUNT-1:0] verticalFieldSelectIndex_ff, refFromBottom_ff, refFromCurrentFrame_ff;
  logic [21:0]          expQ[$];
  logic [21:0]          e;
  int                   err_total, checks;

  mbfd_decode mbfd_decode_i (.core_clk(core_clk), .rst_n(rst_n), .recordValid(recordValid),
    .patternWord(patternWord), .recordWordOneHigh(recordWordOneHigh), .recordWordOneLow(recordWordOneLow),
    .pPicture(pPicture), .fieldPrediction(fieldPrediction), .currentIsBottom(currentIsBottom),
    .decodeValid_ff(decodeValid_ff), .blockPresent_ff(blockPresent_ff),
    .blueChromaBlockPresent_ff(blueChromaBlockPresent_ff), .redChromaBlockPresent_ff(redChromaBlockPresent_ff),
    .verticalFieldSelectIndex_ff(verticalFieldSelectIndex_ff), .refFromBottom_ff(refFromBottom_ff),
    .refFromCurrentFrame_ff(refFromCurrentFrame_ff), .secondField_ff(secondField_ff),
    .secondFieldMisuse_ff(secondFieldMisuse_ff));

  // ==========================================================================
  // clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one cycle per call, a record when v is set; reserved bits stay random so they must not matter
  task automatic send(input logic v, input logic pp, input logic fp, input logic cb, input logic keep);
    logic [3:0]  cf;
    logic [31:0] w;
    seed = xs(seed);
    patternWord = seed;
    seed = xs(seed);
    recordWordOneHigh = seed;
    seed = xs(seed);
    w = seed;
    // a well-behaved producer clears the second-field flag outside field P
    if (keep && !(pp && fp)) w[SECOND_FIELD_BIT] = 1'b0;
    recordWordOneLow = w;
    recordValid = v;
    pPicture = pp;
    fieldPrediction = fp;
    currentIsBottom = cb;
    for (int i = 0; i < 4; i++) cf[i] = pp & fp & w[27] & (w[28+i] != cb);
    if (v) expQ.push_back({patternWord[11:6], patternWord[7], patternWord[6], w[31:28], w[31:28], cf,
                           w[27], w[27] & ~(pp & fp)});
    @(posedge core_clk);
    #1;
  endtask : send

  // ==========================================================================
  // monitor: every answer takes the oldest note
  always @(negedge core_clk) begin
    if (decodeValid_ff === 1'b1) begin
      if (expQ.size() == 0) cmp(8'h01, 8'h00);
      else begin
        e = expQ.pop_front();
        cmp(8'(blockPresent_ff), 8'(e[21:16]));
        cmp(8'({blueChromaBlockPresent_ff, redChromaBlockPresent_ff}), 8'(e[15:14]));
        cmp(8'(verticalFieldSelectIndex_ff), 8'(e[13:10]));
        cmp(8'(refFromBottom_ff), 8'(e[9:6]));
        cmp(8'(refFromCurrentFrame_ff), 8'(e[5:2]));
        cmp(8'(secondField_ff), 8'(e[1]));
        cmp(8'(secondFieldMisuse_ff), 8'(e[0]));
      end
    end
  end

  task automatic wrap_up;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // watchdog well beyond the hundred or so cycles of the sequence
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  initial begin
    {rst_n, recordValid, pPicture, fieldPrediction, currentIsBottom} = '0;
    {patternWord, recordWordOneHigh, recordWordOneLow} = '0;
    seed = 32'h0000_004A;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    cmp(8'({decodeValid_ff, blockPresent_ff}), 8'h00);
    cmp(8'({verticalFieldSelectIndex_ff, refFromBottom_ff}), 8'h00);
    // every picture context, back to back; c[3] picks a producer that keeps the flag rule
    for (int c = 0; c < 32; c++) send(1'b1, c[0], c[1], c[2], c[3]);
    send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cmp(8'(decodeValid_ff), 8'h00);
    cmp(8'(blockPresent_ff), 8'(e[21:16]));
    // reset in mid-run clears every output without waiting for a record
    rst_n = 1'b0;
    @(posedge core_clk);
    #1;
    cmp(8'({decodeValid_ff, blockPresent_ff}), 8'h00);
    cmp(8'({verticalFieldSelectIndex_ff, refFromBottom_ff}), 8'h00);
    cmp(8'({refFromCurrentFrame_ff, secondField_ff, secondFieldMisuse_ff}), 8'h00);
    cmp(8'({blueChromaBlockPresent_ff, redChromaBlockPresent_ff}), 8'h00);
    rst_n = 1'b1;
    // random gaps between records, first one right at the release
    for (int n = 0; n < 60; n++) send(seed[3], seed[4], seed[5], seed[6], seed[7]);
    send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk);
    cmp(8'(expQ.size()), 8'h00);
    wrap_up();
  end
endmodule : tb_top
